// >>> pkg/lbc_pkg.sv
// package: constants and carrier types of the lane barrier controller
package lbc_pkg;
	// clock and time base
	localparam int CLK_PERIOD_NS = 5;
	localparam int MS_IN_NS = 1000000;
	localparam int CYC_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
	localparam int TICK_W = 18;
	// input filter and chime length, in milliseconds
	localparam logic [3:0] DEBOUNCE_MS = 4'h5;
	localparam logic [15:0] CHIME_MS = 16'h03e8;
	// register byte offsets
	localparam logic [7:0] REG_BEAM_DLY = 8'h00;
	localparam logic [7:0] REG_ARST_DLY = 8'h04;
	localparam logic [7:0] REG_UNUSED_DLY = 8'h08;
	localparam logic [7:0] REG_TG_GAP = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	// reset values of the delay registers, in milliseconds
	localparam logic [15:0] RST_BEAM_DLY = 16'h1388;
	localparam logic [15:0] RST_ARST_DLY = 16'h2710;
	localparam logic [15:0] RST_UNUSED_DLY = 16'h1388;
	localparam logic [15:0] RST_TG_GAP = 16'h00c8;
	// beam positions along the lane
	localparam int BEAM_ENTRY = 0;
	localparam int BEAM_MID = 1;
	localparam int BEAM_SAFE = 2;
	localparam int BEAM_SECURE = 3;
	localparam int NBEAM = 4;
	// field inputs: 1 = contact closed, beam blocked, arm at sensor
	typedef struct packed {
		logic arm_at_ret;
		logic arm_at_ext;
		logic [NBEAM-1:0] beam;
		logic day;
		logic fire;
		logic barrier_byp;
		logic lane_byp;
		logic invalid_card;
		logic exit_card;
		logic entry_card;
	} lbc_in_t;
	localparam int NIN = $bits(lbc_in_t);
	// classic wishbone request from the master
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} lbc_wb_req_t;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_GRANT_IN = 7'h02,
		ST_GRANT_OUT = 7'h04,
		ST_PASS_IN = 7'h08,
		ST_PASS_OUT = 7'h10,
		ST_TAILGATE = 7'h20,
		ST_VIOL_IN = 7'h40
	} lbc_state_t;
endpackage

// >>> hw/lbc_lane_ctrl.sv
// lane barrier controller: input filter, lane sequencer, alarms, registers
// Operation
// - barriers extended by default, retract on entry
// - hold retracted until every beam is clear
// - one person per card, else alarm
// - alarm drives sounder and alarm relay
// - day contact closed free exit, open card-out
// - free exit retracts on outward person
// - tailgate: extend once first person clears
// - tailgate decided upstream, adjustable sensitivity
// - barrier bypass retracts, lane logic keeps running
// - emergency override retracts, never extends
// - fire contact closed disables barriers
// - card-out exit without card alarms, retracts
// - invalid card chimes, barriers stay extended
// - lane bypass contact reported on bypass relay
// - sounder on exactly while alarm active
// - green when entry enabled, red when secured
// - beam blocked too long raises alarm
// - alarm clears after adjustable reset delay
// - unused grant cancelled after adjustable delay
// - no barrier motion while area occupied, except fire contact retracts
// - acknowledge relays follow passage direction
`timescale 1ns/1ps
`default_nettype none
module lbc_lane_ctrl import lbc_pkg::*; #(
	parameter int TICK_CYC = CYC_PER_MS
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// raw field inputs
	input wire lbc_in_t pins,
	// register bus
	input wire lbc_wb_req_t wb_req,
	output logic [31:0] wb_dat,
	output logic wb_ack,
	// barrier motor commands
	output logic arm_extend,
	output logic arm_retract,
	// relays, sounders and display
	output logic alarm_relay,
	output logic bypass_relay,
	output logic entry_ack,
	output logic exit_ack,
	output logic sounder,
	output logic chime,
	output logic lamp_green,
	output logic lamp_red
);
	logic [TICK_W-1:0] tick_cnt_r;
	logic tick_r;
	logic [NIN-1:0] s1_r, s2_r, db_r;
	lbc_in_t in_d;
	logic ent_q_r, ext_q_r, inv_q_r;
	logic ent_rise, ext_rise, inv_rise;
	logic ent_pend_r, ext_pend_r, take_in, take_out;
	logic [NBEAM-1:0] beams, beam_q_r;
	logic lane_clear, safe_busy, quiet;
	lbc_state_t st_r, st_nxt;
	logic viol_ev, bb_ev, alarm_ev, alarm_nxt, arst_done, unused_done;
	logic [15:0] unused_cnt_r, gap_cnt_r, bb_cnt_r, arst_cnt_r, chime_cnt_r;
	logic sep_r, tg_hit, bb_fired_r, want_ret, green_nxt;
	logic [15:0] beam_dly_r, arst_dly_r, unused_dly_r, tg_gap_r;
	logic wb_req_on, wb_wr;
	logic [31:0] rd_data;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// millisecond enable from the system clock
	always_ff @(posedge clk) begin
		if (reset || tick_cnt_r == TICK_W'(TICK_CYC - 1)) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
		end
		tick_r <= !reset && tick_cnt_r == TICK_W'(TICK_CYC - 1);
	end

	// two-stage synchroniser on every field input
	always_ff @(posedge clk) begin
		if (reset) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= pins;
			s2_r <= s1_r;
		end
	end

	// per-input debounce: a change must hold for DEBOUNCE_MS ticks
	for (genvar g = 0; g < NIN; g++) begin : g_deb
		logic [3:0] dcnt_r;
		always_ff @(posedge clk) begin
			if (reset) begin
				dcnt_r <= '0;
				db_r[g] <= 1'b0;
			end else if (s2_r[g] == db_r[g]) begin
				dcnt_r <= '0;
			end else if (tick_r) begin
				if (dcnt_r == DEBOUNCE_MS - 4'h1) begin
					dcnt_r <= '0;
					db_r[g] <= s2_r[g];
				end else begin
					dcnt_r <= dcnt_r + 4'h1;
				end
			end
		end
	end

	assign in_d = lbc_in_t'(db_r);
	assign beams = in_d.beam;
	assign lane_clear = (beams == '0);
	assign safe_busy = beams[BEAM_SAFE];
	// closed fire or lane bypass contact means barriers disabled, passage is free
	assign quiet = in_d.fire | in_d.lane_byp;

	always_ff @(posedge clk) begin
		if (reset) begin
			ent_q_r <= 1'b0;
			ext_q_r <= 1'b0;
			inv_q_r <= 1'b0;
		end else begin
			ent_q_r <= in_d.entry_card;
			ext_q_r <= in_d.exit_card;
			inv_q_r <= in_d.invalid_card;
		end
	end
	assign ent_rise = in_d.entry_card & ~ent_q_r;
	assign ext_rise = in_d.exit_card & ~ext_q_r;
	assign inv_rise = in_d.invalid_card & ~inv_q_r;

	// card pulses latched as pending grants; a new pulse wins the take
	always_ff @(posedge clk) begin
		if (reset) begin
			ent_pend_r <= 1'b0;
			ext_pend_r <= 1'b0;
		end else begin
			ent_pend_r <= ent_rise | (ent_pend_r & ~take_in);
			// exit card only counts in card-out operation
			ext_pend_r <= (ext_rise & ~in_d.day) | (ext_pend_r & ~take_out);
		end
	end
	assign take_in = (st_r == ST_IDLE && ent_pend_r) || (tg_hit && ent_pend_r);
	assign take_out = (st_r == ST_IDLE && !ent_pend_r && ext_pend_r)
		|| in_d.day;

	// unused grant timer
	always_ff @(posedge clk) begin
		if (reset || (st_r != ST_GRANT_IN && st_r != ST_GRANT_OUT)) begin
			unused_cnt_r <= '0;
		end else if (tick_r && !unused_done) begin
			unused_cnt_r <= unused_cnt_r + 16'h1;
		end
	end
	assign unused_done = unused_cnt_r >= unused_dly_r;

	// upstream gap on the entry beam separates two persons
	always_ff @(posedge clk) begin
		if (reset || st_r != ST_PASS_IN || beams[BEAM_ENTRY]) begin
			gap_cnt_r <= '0;
		end else if (tick_r && gap_cnt_r != 16'hffff) begin
			gap_cnt_r <= gap_cnt_r + 16'h1;
		end
		if (reset || st_r != ST_PASS_IN || (tg_hit && ent_pend_r)) begin
			sep_r <= 1'b0;
		end else if (!beams[BEAM_ENTRY] && gap_cnt_r >= tg_gap_r) begin
			sep_r <= 1'b1;
		end
	end
	assign tg_hit = st_r == ST_PASS_IN && sep_r && beams[BEAM_ENTRY];

	// lane sequencer
	always_comb begin
		st_nxt = st_r;
		viol_ev = 1'b0;
		case (st_r)
			ST_IDLE: begin
				if (ent_pend_r) begin
					st_nxt = ST_GRANT_IN;
				end else if (ext_pend_r) begin
					st_nxt = ST_GRANT_OUT;
				end else if (beams[BEAM_ENTRY]) begin
					st_nxt = ST_VIOL_IN;
					viol_ev = 1'b1;
				end else if (beams[BEAM_SECURE]) begin
					st_nxt = ST_PASS_OUT;
					viol_ev = ~in_d.day;
				end
			end
			ST_GRANT_IN: begin
				if (beams[BEAM_ENTRY]) begin
					st_nxt = ST_PASS_IN;
				end else if (unused_done) begin
					st_nxt = ST_IDLE;
				end
			end
			ST_GRANT_OUT: begin
				if (beams[BEAM_SECURE]) begin
					st_nxt = ST_PASS_OUT;
				end else if (unused_done) begin
					st_nxt = ST_IDLE;
				end
			end
			ST_PASS_IN: begin
				if (lane_clear) begin
					st_nxt = ST_IDLE;
				end else if (tg_hit && !ent_pend_r) begin
					st_nxt = ST_TAILGATE;
					viol_ev = 1'b1;
				end
			end
			ST_PASS_OUT, ST_TAILGATE, ST_VIOL_IN: begin
				if (lane_clear) begin
					st_nxt = ST_IDLE;
				end
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_r <= ST_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// beam held in one pattern too long
	always_ff @(posedge clk) begin
		if (reset) begin
			beam_q_r <= '0;
			bb_cnt_r <= '0;
			bb_fired_r <= 1'b0;
		end else begin
			beam_q_r <= beams;
			if (beams != beam_q_r || lane_clear) begin
				bb_cnt_r <= '0;
				bb_fired_r <= 1'b0;
			end else begin
				if (tick_r && bb_cnt_r < beam_dly_r) begin
					bb_cnt_r <= bb_cnt_r + 16'h1;
				end
				if (bb_ev) begin
					bb_fired_r <= 1'b1;
				end
			end
		end
	end
	assign bb_ev = !bb_fired_r && !lane_clear && beams == beam_q_r
		&& bb_cnt_r >= beam_dly_r;

	// alarm with automatic reset; a new event wins over the reset
	assign alarm_ev = (viol_ev | bb_ev) & ~quiet;
	assign arst_done = sounder && arst_cnt_r >= arst_dly_r;
	assign alarm_nxt = alarm_ev | (sounder & ~arst_done);
	always_ff @(posedge clk) begin
		if (reset || alarm_ev || !sounder) begin
			arst_cnt_r <= '0;
		end else if (tick_r) begin
			arst_cnt_r <= arst_cnt_r + 16'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			sounder <= 1'b0;
			alarm_relay <= 1'b0;
		end else begin
			sounder <= alarm_nxt;
			alarm_relay <= alarm_nxt;
		end
	end

	// barrier motion
	assign want_ret = st_nxt == ST_GRANT_IN || st_nxt == ST_GRANT_OUT
		|| st_nxt == ST_PASS_IN || st_nxt == ST_PASS_OUT;
	always_ff @(posedge clk) begin
		if (reset) begin
			arm_extend <= 1'b1;
			arm_retract <= 1'b0;
		end else if (in_d.fire) begin
			arm_extend <= 1'b0;
			arm_retract <= 1'b1;
		end else if (safe_busy) begin
			arm_extend <= arm_extend;
			arm_retract <= arm_retract;
		end else if (in_d.barrier_byp || in_d.lane_byp) begin
			arm_extend <= 1'b0;
			arm_retract <= 1'b1;
		end else begin
			arm_extend <= ~want_ret;
			arm_retract <= want_ret;
		end
	end

	// acknowledge relays, display and bypass report
	assign green_nxt = st_nxt == ST_GRANT_IN || quiet;
	always_ff @(posedge clk) begin
		if (reset) begin
			entry_ack <= 1'b0;
			exit_ack <= 1'b0;
			lamp_green <= 1'b0;
			lamp_red <= 1'b1;
			bypass_relay <= 1'b0;
		end else begin
			entry_ack <= st_nxt == ST_PASS_IN || st_nxt == ST_TAILGATE
				|| st_nxt == ST_VIOL_IN;
			exit_ack <= st_nxt == ST_PASS_OUT;
			lamp_green <= green_nxt;
			lamp_red <= ~green_nxt;
			bypass_relay <= in_d.lane_byp;
		end
	end

	// access-denied chime; the lane state is left untouched
	always_ff @(posedge clk) begin
		if (reset) begin
			chime_cnt_r <= '0;
			chime <= 1'b0;
		end else begin
			if (inv_rise) begin
				chime_cnt_r <= CHIME_MS;
			end else if (tick_r && chime_cnt_r != 16'h0) begin
				chime_cnt_r <= chime_cnt_r - 16'h1;
			end
			chime <= inv_rise || chime_cnt_r != 16'h0;
		end
	end

	// wishbone slave: ack one cycle after the request, dropped next cycle
	function automatic logic [15:0] upd16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0]) begin
			r[7:0] = d[7:0];
		end
		if (sel[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	assign wb_req_on = wb_req.cyc & wb_req.stb;
	assign wb_wr = wb_req_on & wb_ack & wb_req.we;
	always_comb begin
		case (wb_req.adr)
			REG_BEAM_DLY: rd_data = 32'(beam_dly_r);
			REG_ARST_DLY: rd_data = 32'(arst_dly_r);
			REG_UNUSED_DLY: rd_data = 32'(unused_dly_r);
			REG_TG_GAP: rd_data = 32'(tg_gap_r);
			REG_STATUS: rd_data = 32'({in_d, chime, sounder, st_r});
			default: rd_data = 32'h0;
		endcase
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			wb_ack <= 1'b0;
			wb_dat <= 32'h0;
		end else begin
			wb_ack <= wb_req_on & ~wb_ack;
			wb_dat <= rd_data;
		end
	end
	// field-adjustable delays and tailgate sensitivity
	always_ff @(posedge clk) begin
		if (reset) begin
			beam_dly_r <= RST_BEAM_DLY;
			arst_dly_r <= RST_ARST_DLY;
			unused_dly_r <= RST_UNUSED_DLY;
			tg_gap_r <= RST_TG_GAP;
		end else if (wb_wr) begin
			case (wb_req.adr)
				REG_BEAM_DLY: beam_dly_r <= upd16(beam_dly_r, wb_req.dat,
					wb_req.sel);
				REG_ARST_DLY: arst_dly_r <= upd16(arst_dly_r, wb_req.dat,
					wb_req.sel);
				REG_UNUSED_DLY: unused_dly_r <= upd16(unused_dly_r,
					wb_req.dat, wb_req.sel);
				REG_TG_GAP: tg_gap_r <= upd16(tg_gap_r, wb_req.dat,
					wb_req.sel);
				default: tg_gap_r <= tg_gap_r;
			endcase
		end
	end

	a_default_ext:
	assert property (st_r == ST_IDLE && st_nxt == ST_IDLE && !safe_busy
		&& !quiet && !in_d.barrier_byp |=> arm_extend && !arm_retract)
		else $error("idle lane did not extend barriers");
	a_grant_retract:
	assert property (st_nxt == ST_GRANT_IN && !safe_busy |=> arm_retract)
		else $error("entry grant did not retract barriers");
	a_pass_held:
	assert property (st_r == ST_PASS_IN && !lane_clear && !tg_hit
		&& !safe_busy |=> arm_retract)
		else $error("barriers moved during passage");
	a_alarm_sounds:
	assert property (alarm_ev |=> sounder && alarm_relay)
		else $error("alarm event did not sound");
	a_sounder_ends:
	assert property (sounder && arst_done && !alarm_ev |=> !sounder)
		else $error("sounder outlived alarm");
	a_fire_no_ext:
	assert property (in_d.fire |=> !arm_extend && arm_retract)
		else $error("extend under emergency override");
	a_safety_hold:
	assert property (safe_busy && !in_d.fire |=> $stable(arm_extend))
		else $error("barrier moved with area occupied");
	a_chime_on:
	assert property (inv_rise |=> chime)
		else $error("invalid card did not chime");
	a_unused_drop:
	assert property (st_r == ST_GRANT_IN && unused_done
		&& !beams[BEAM_ENTRY] |=> st_r == ST_IDLE)
		else $error("unused grant not cancelled");
	a_bypass_rep:
	assert property (in_d.lane_byp |=> bypass_relay ##1 bypass_relay
		or !in_d.lane_byp)
		else $error("lane bypass not reported");
	a_wb_ack_one:
	assert property (wb_ack |=> !wb_ack)
		else $error("ack held two cycles");
endmodule
`default_nettype wire

// >>> tb/lbc_card_sys.sv
// card access system model: momentary card contacts toward the lane
`timescale 1ns/1ps
`default_nettype none
module lbc_card_sys #(
	parameter int PULSE_CYC = 200
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// bench request: 1 entry, 2 exit, 4 denied
	input wire logic [2:0] req,
	// contacts {invalid, exit, entry}, 1 = closed
	output logic [2:0] card
);
	logic [15:0] cnt_r;
	// one contact at a time, held far below one second
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_r <= 16'h0000;
			card <= 3'h0;
		end else if (req != 3'h0) begin
			cnt_r <= 16'(PULSE_CYC);
			card <= req;
		end else if (cnt_r != 16'h0000) begin
			cnt_r <= cnt_r - 16'h0001;
		end else begin
			card <= 3'h0;
		end
	end
endmodule
`default_nettype wire

// >>> tb/lane_barrier_controller_test.sv
// lane barrier controller testbench
`timescale 1ns/1ps
`default_nettype none
module lane_barrier_controller_test import lbc_pkg::*;;
	localparam int T = 10;
	localparam int EXT = 9, RET = 8, ALM = 7, BYP = 6, ENA = 5;
	localparam int EXA = 4, SND = 3, CHM = 2, GRN = 1, RED = 0;
	logic clk = 1'b0;
	logic reset = 1'b1;
	lbc_wb_req_t wb_req = '0;
	logic [31:0] wb_dat;
	logic [31:0] rd;
	logic wb_ack;
	wire [9:0] o;
	logic [3:0] beam = 4'h0;
	logic day = 1'b0, fire = 1'b0, bbyp = 1'b0, lbyp = 1'b0;
	logic [2:0] req = 3'h0;
	logic [2:0] card;
	logic [15:0] g;
	lbc_in_t pins;
	int fail_count = 0, checks = 0, cyc = 0;
	// arm sensors simply follow the motor commands
	assign pins = '{o[RET], o[EXT], beam, day, fire, bbyp, lbyp,
		card[2], card[1], card[0]};
	lbc_lane_ctrl #(.TICK_CYC(T)) DUT (.clk(clk), .reset(reset),
		.pins(pins), .wb_req(wb_req), .wb_dat(wb_dat), .wb_ack(wb_ack),
		.arm_extend(o[EXT]), .arm_retract(o[RET]), .alarm_relay(o[ALM]),
		.bypass_relay(o[BYP]), .entry_ack(o[ENA]), .exit_ack(o[EXA]),
		.sounder(o[SND]), .chime(o[CHM]), .lamp_green(o[GRN]),
		.lamp_red(o[RED]));
	lbc_card_sys #(.PULSE_CYC(20 * T)) CARD (.clk(clk), .reset(reset),
		.req(req), .card(card));
	initial begin
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			end_of_test();
		end
	end
	// wait bound in cycles: delay in ticks plus filter margin
	function automatic int tk(input int ms);
		return (ms + 20) * T;
	endfunction
	task automatic chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic wt(input int i, input logic v, input int lim);
		int n;
		n = 0;
		while (o[i] !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk(o[i] === v, $sformatf("output %0d not %0b", i, v));
	endtask
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		wb_req <= '{1'b1, 1'b1, we, a, 4'hf, d};
		do begin
			@(posedge clk);
		end while (wb_ack !== 1'b1);
		rd = wb_dat;
		wb_req <= '0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
		wb(1'b0, a, 32'h0);
		chk(rd === {16'h0000, e}, $sformatf("read %0h", a));
	endtask
	task automatic grant(input logic [2:0] r);
		@(posedge clk);
		req <= r;
		@(posedge clk);
		req <= 3'h0;
	endtask
	task automatic sb(input logic [3:0] b);
		repeat ($urandom_range(12, 8) * T) @(posedge clk);
		beam <= b;
	endtask
	task automatic end_of_test();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		void'($urandom(8));
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		@(posedge clk);
		chk(o === 10'h201, "reset outputs");
		rdchk(REG_BEAM_DLY, RST_BEAM_DLY);
		rdchk(REG_ARST_DLY, RST_ARST_DLY);
		rdchk(REG_UNUSED_DLY, RST_UNUSED_DLY);
		rdchk(REG_TG_GAP, RST_TG_GAP);
		rdchk(8'h20, 16'h0000);
		g = 16'($urandom_range(40, 20));
		wb(1'b1, REG_TG_GAP, {16'h0000, g});
		rdchk(REG_TG_GAP, g);
		wb(1'b1, REG_BEAM_DLY, 32'h3c);
		wb(1'b1, REG_ARST_DLY, 32'h64);
		wb(1'b1, REG_UNUSED_DLY, 32'h50);
		// valid entry walk
		grant(3'h1);
		wt(RET, 1'b1, tk(10));
		chk(o[GRN] === 1'b1 && o[RED] === 1'b0, "green");
		sb(4'h1);
		wt(ENA, 1'b1, tk(10));
		sb(4'h6);
		sb(4'hc);
		sb(4'h8);
		chk(o[RET] === 1'b1 && o[SND] === 1'b0, "held");
		sb(4'h0);
		wt(EXT, 1'b1, tk(10));
		chk(o[ENA] === 1'b0 && o[RED] === 1'b1, "back");
		// entry without card
		sb(4'h1);
		wt(SND, 1'b1, tk(10));
		chk(o[ALM] & o[ENA] & o[EXT], "violation");
		sb(4'h0);
		repeat (40 * T) @(posedge clk);
		chk(o[SND] === 1'b1, "early reset");
		wt(SND, 1'b0, tk(60));
		chk(o[ALM] === 1'b0, "relay clear");
		// denied card
		grant(3'h4);
		wt(CHM, 1'b1, tk(10));
		chk(o[EXT] === 1'b1 && o[SND] === 1'b0, "denied");
		wt(CHM, 1'b0, tk(1000));
		// free exit in day mode
		day <= 1'b1;
		sb(4'h8);
		wt(RET, 1'b1, tk(10));
		chk(o[EXA] === 1'b1 && o[SND] === 1'b0, "free exit");
		sb(4'h0);
		wt(EXT, 1'b1, tk(10));
		// night exit without card
		day <= 1'b0;
		sb(4'h8);
		wt(RET, 1'b1, tk(10));
		chk(o[SND] === 1'b1 && o[EXA] === 1'b1, "exit alarm");
		sb(4'h0);
		wt(EXT, 1'b1, tk(10));
		wt(SND, 1'b0, tk(100));
		// night exit with card
		grant(3'h2);
		wt(RET, 1'b1, tk(10));
		sb(4'h8);
		wt(EXA, 1'b1, tk(10));
		chk(o[SND] === 1'b0 && o[EXA] === 1'b1, "card exit");
		sb(4'h0);
		wt(EXT, 1'b1, tk(10));
		// grant never used
		grant(3'h1);
		wt(RET, 1'b1, tk(10));
		repeat (60 * T) @(posedge clk);
		chk(o[RET] === 1'b1, "grant kept");
		wt(EXT, 1'b1, tk(40));
		// beam held blocked in a passage
		grant(3'h1);
		wt(RET, 1'b1, tk(10));
		sb(4'h1);
		repeat (30 * T) @(posedge clk);
		chk(o[SND] === 1'b0, "block early");
		wt(SND, 1'b1, tk(60));
		sb(4'h0);
		wt(EXT, 1'b1, tk(10));
		wt(SND, 1'b0, tk(100));
		// tailgater enters while first person is in the barrier area
		grant(3'h1);
		wt(RET, 1'b1, tk(10));
		sb(4'h1);
		wt(ENA, 1'b1, tk(10));
		sb(4'h4);
		repeat (45 * T) @(posedge clk);
		beam <= 4'h5;
		wt(SND, 1'b1, tk(10));
		chk(o[RET] === 1'b1 && o[ENA] === 1'b1, "tailgate hold");
		sb(4'h1);
		wt(EXT, 1'b1, tk(10));
		sb(4'h0);
		wt(SND, 1'b0, tk(100));
		// barrier bypass keeps detection
		bbyp <= 1'b1;
		wt(RET, 1'b1, tk(10));
		sb(4'h1);
		wt(ENA, 1'b1, tk(10));
		sb(4'h0);
		bbyp <= 1'b0;
		wt(EXT, 1'b1, tk(10));
		wt(SND, 1'b0, tk(100));
		// fire override over bypass
		fire <= 1'b1;
		bbyp <= 1'b1;
		wt(RET, 1'b1, tk(10));
		sb(4'h1);
		sb(4'h0);
		bbyp <= 1'b0;
		sb(4'h0);
		chk(o[RET] === 1'b1 && o[EXT] === 1'b0, "fire");
		fire <= 1'b0;
		wt(EXT, 1'b1, tk(10));
		// lane bypass relay
		lbyp <= 1'b1;
		wt(BYP, 1'b1, tk(10));
		lbyp <= 1'b0;
		wt(BYP, 1'b0, tk(10));
		end_of_test();
	end
endmodule
`default_nettype wire
